//--- prsrd_regs.vh
// register map, field positions and timing constants of the pressure readout block
`ifndef PRSRD_REGS_VH
`define PRSRD_REGS_VH
`define PRSRD_DEV_ADDR      7'h6D
`define PRSRD_OFS_PRES_HI   8'h06
`define PRSRD_OFS_PRES_MID  8'h07
`define PRSRD_OFS_PRES_LO   8'h08
`define PRSRD_OFS_TEMP_HI   8'h09
`define PRSRD_OFS_TEMP_LO   8'h0A
`define PRSRD_OFS_CMD       8'h30
`define PRSRD_OFS_SYS       8'hA5
`define PRSRD_OFS_CHAN      8'hA6
`define PRSRD_RST_CMD       8'h00
`define PRSRD_RST_SYS       8'h01
`define PRSRD_RST_CHAN      8'h00
`define PRSRD_CMD_SCO_BIT   3
`define PRSRD_MC_COMBINED   3'h2
`define PRSRD_MC_SLEEP      3'h3
`define PRSRD_SYS_LDO_BIT   3
`define PRSRD_SYS_UNI_BIT   2
`define PRSRD_SYS_RAW_BIT   1
`define PRSRD_CHAN_SWAP_BIT 6
`define PRSRD_SLEEP_STEP_US 62500
`define PRSRD_CLK_MHZ       250
`endif

//--- prsrd_top.v
// i2c register slave with conversion sequencer for the pressure/temperature readout
`timescale 1ns/1ns
`include "prsrd_regs.vh"
module prsrd_top #(
    parameter CONV_CYCLES = 2500000,
    parameter STEP_CYCLES = `PRSRD_SLEEP_STEP_US * `PRSRD_CLK_MHZ
) (
    // clock and reset
    input  wire        clk,
    input  wire        nrst,
    // i2c pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    // converter front end
    input  wire [23:0] adc_pres_raw,
    input  wire [23:0] adc_pres_cal,
    input  wire [15:0] adc_temp,
    output reg         conv_busy,
    output reg         conv_temp_phase,
    output reg         regulator_voltage_select,
    output reg         input_swap,
    output reg  [2:0]  gain_code,
    output reg  [2:0]  oversampling_code,
    output reg  [8:0]  oversampling_log2
);
    localparam ST_IDLE = 5'h01;
    localparam ST_ADDR = 5'h02;
    localparam ST_WR   = 5'h04;
    localparam ST_RD   = 5'h08;
    localparam ST_ACK  = 5'h10;

    localparam CV_IDLE  = 3'h1;
    localparam CV_TEMP  = 3'h2;
    localparam CV_PRES  = 3'h4;

    // two-stage synchronisers; stage two and a one-cycle delayed copy of it feed logic
    reg [1:0] scl_s_r, sda_s_r;
    reg       scl_d_r, sda_d_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_in};
            sda_s_r <= {sda_s_r[0], sda_in};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end
    wire scl_h    = scl_s_r[1];
    wire sda_h    = sda_s_r[1];
    wire scl_rise = scl_h & ~scl_d_r;
    wire scl_fall = ~scl_h & scl_d_r;
    wire start_c  = scl_h & scl_d_r & ~sda_h & sda_d_r;
    wire stop_c   = scl_h & scl_d_r & sda_h & ~sda_d_r;

    reg [4:0]  st_r;
    reg [3:0]  bit_r;
    reg [7:0]  shift_r;
    reg        first_r;
    reg        rd_dir_r;
    reg        ack_drive_r;
    reg        mack_r;
    reg [7:0]  ptr_r;
    reg [7:0]  cmd_r;
    reg [7:0]  sys_r;
    reg [7:0]  chan_r;
    reg [23:0] pres_r;
    reg [15:0] temp_r;
    reg [2:0]  cv_r;
    reg [31:0] cnt_r;
    reg [3:0]  gap_steps_r;
    reg        gap_r;
    reg        wr_cmd_p;

    // register read mux
    reg [7:0] rd_data;
    always @* begin
        case (ptr_r)
            `PRSRD_OFS_PRES_HI:  rd_data = pres_r[23:16];
            `PRSRD_OFS_PRES_MID: rd_data = pres_r[15:8];
            `PRSRD_OFS_PRES_LO:  rd_data = pres_r[7:0];
            `PRSRD_OFS_TEMP_HI:  rd_data = temp_r[15:8];
            `PRSRD_OFS_TEMP_LO:  rd_data = temp_r[7:0];
            `PRSRD_OFS_CMD:      rd_data = cmd_r;
            `PRSRD_OFS_SYS:      rd_data = sys_r;
            `PRSRD_OFS_CHAN:     rd_data = chan_r;
            default:             rd_data = 8'h00;
        endcase
    end

    // i2c slave engine; sda changes only on scl falling edges
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r        <= ST_IDLE;
            bit_r       <= 4'h0;
            shift_r     <= 8'h00;
            first_r     <= 1'b0;
            rd_dir_r    <= 1'b0;
            ack_drive_r <= 1'b0;
            mack_r      <= 1'b0;
            ptr_r       <= 8'h00;
            sda_out     <= 1'b1;
            sda_oe      <= 1'b0;
        end else if (start_c) begin
            st_r    <= ST_ADDR;
            bit_r   <= 4'h0;
            sda_oe  <= 1'b0;
        end else if (stop_c) begin
            st_r    <= ST_IDLE;
            sda_oe  <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: sda_oe <= 1'b0;
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_h};
                        bit_r   <= bit_r + 4'h1;
                    end
                    if (scl_fall && bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        if (st_r == ST_ADDR) begin
                            if (shift_r[7:1] == `PRSRD_DEV_ADDR) begin
                                rd_dir_r    <= shift_r[0];
                                first_r     <= 1'b1;
                                ack_drive_r <= 1'b1;
                                sda_out     <= 1'b0;
                                sda_oe      <= 1'b1;
                                st_r        <= ST_ACK;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end else begin
                            if (first_r)
                                ptr_r <= shift_r;
                            else
                                ptr_r <= ptr_r + 8'h01;
                            first_r     <= 1'b0;
                            rd_dir_r    <= 1'b0;
                            ack_drive_r <= 1'b1;
                            sda_out     <= 1'b0;
                            sda_oe      <= 1'b1;
                            st_r        <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        ack_drive_r <= 1'b0;
                        bit_r       <= 4'h0;
                        if (rd_dir_r) begin
                            shift_r <= {rd_data[6:0], 1'b0};
                            sda_out <= rd_data[7];
                            sda_oe  <= ~rd_data[7];
                            bit_r   <= 4'h1;
                            st_r    <= ST_RD;
                        end else begin
                            sda_out <= 1'b1;
                            sda_oe  <= 1'b0;
                            st_r    <= ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise && bit_r == 4'h9)
                        mack_r <= ~sda_h;
                    if (scl_fall) begin
                        if (bit_r == 4'h8) begin
                            sda_out <= 1'b1;
                            sda_oe  <= 1'b0;
                            ptr_r   <= ptr_r + 8'h01;
                            bit_r   <= 4'h9;
                        end else if (bit_r == 4'h9) begin
                            if (mack_r) begin
                                shift_r <= {rd_data[6:0], 1'b0};
                                sda_out <= rd_data[7];
                                sda_oe  <= ~rd_data[7];
                                bit_r   <= 4'h1;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end else begin
                            sda_out <= shift_r[7];
                            sda_oe  <= ~shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                            bit_r   <= bit_r + 4'h1;
                        end
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // register write strobe: data byte finished, not the pointer byte
    wire wr_now = (st_r == ST_WR) && scl_fall && (bit_r == 4'h8) && !first_r;
    wire conv_end = (cv_r == CV_PRES) && (cnt_r == 32'd0);
    wire sleep_mode = (cmd_r[2:0] == `PRSRD_MC_SLEEP);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_r    <= `PRSRD_RST_CMD;
            sys_r    <= `PRSRD_RST_SYS;
            chan_r   <= `PRSRD_RST_CHAN;
            wr_cmd_p <= 1'b0;
        end else begin
            wr_cmd_p <= 1'b0;
            if (wr_now && ptr_r == `PRSRD_OFS_CMD) begin
                cmd_r    <= shift_r;
                wr_cmd_p <= shift_r[`PRSRD_CMD_SCO_BIT];
            end else if (conv_end && !sleep_mode) begin
                cmd_r[`PRSRD_CMD_SCO_BIT] <= 1'b0;
            end
            if (wr_now && ptr_r == `PRSRD_OFS_SYS)
                sys_r <= shift_r;
            if (wr_now && ptr_r == `PRSRD_OFS_CHAN)
                chan_r <= shift_r;
        end
    end

    // conversion sequencer; a fixed cycle count stands in for each conversion
    wire raw_sel  = sys_r[`PRSRD_SYS_RAW_BIT];
    wire unsig    = sys_r[`PRSRD_SYS_UNI_BIT] & raw_sel;
    wire [23:0] pres_src = raw_sel ? adc_pres_raw : adc_pres_cal;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cv_r        <= CV_IDLE;
            cnt_r       <= 32'd0;
            gap_steps_r <= 4'h0;
            gap_r       <= 1'b0;
            pres_r      <= 24'h000000;
            temp_r      <= 16'h0000;
        end else begin
            case (cv_r)
                CV_IDLE: begin
                    if (gap_r) begin
                        if (!sleep_mode || !cmd_r[`PRSRD_CMD_SCO_BIT]) begin
                            gap_r <= 1'b0;
                        end else if (cnt_r != 32'd0) begin
                            cnt_r <= cnt_r - 32'd1;
                        end else if (gap_steps_r != 4'h0) begin
                            gap_steps_r <= gap_steps_r - 4'h1;
                            cnt_r       <= STEP_CYCLES - 1;
                        end else begin
                            gap_r <= 1'b0;
                            cv_r  <= CV_TEMP;
                            cnt_r <= CONV_CYCLES - 1;
                        end
                    end else if (wr_cmd_p && (cmd_r[2:0] == `PRSRD_MC_COMBINED
                                              || sleep_mode)) begin
                        cv_r  <= CV_TEMP;
                        cnt_r <= CONV_CYCLES - 1;
                    end
                end
                CV_TEMP: begin
                    if (cnt_r != 32'd0) begin
                        cnt_r <= cnt_r - 32'd1;
                    end else begin
                        // unsigned output is offset binary: flip the sign bit
                        temp_r <= {adc_temp[15] ^ unsig, adc_temp[14:0]};
                        cv_r   <= CV_PRES;
                        cnt_r  <= CONV_CYCLES - 1;
                    end
                end
                CV_PRES: begin
                    if (cnt_r != 32'd0) begin
                        cnt_r <= cnt_r - 32'd1;
                    end else begin
                        pres_r <= {pres_src[23] ^ unsig, pres_src[22:0]};
                        cv_r   <= CV_IDLE;
                        if (sleep_mode) begin
                            gap_r       <= 1'b1;
                            gap_steps_r <= cmd_r[7:4];
                        end
                    end
                end
                default: cv_r <= CV_IDLE;
            endcase
        end
    end

    // front-end controls, registered
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_busy                <= 1'b0;
            conv_temp_phase          <= 1'b0;
            regulator_voltage_select <= 1'b0;
            input_swap               <= 1'b0;
            gain_code                <= 3'h0;
            oversampling_code        <= 3'h0;
            oversampling_log2        <= 9'h000;
        end else begin
            conv_busy                <= (cv_r != CV_IDLE);
            conv_temp_phase          <= (cv_r == CV_TEMP);
            regulator_voltage_select <= sys_r[`PRSRD_SYS_LDO_BIT];
            input_swap               <= chan_r[`PRSRD_CHAN_SWAP_BIT];
            gain_code                <= chan_r[5:3];
            oversampling_code        <= chan_r[2:0];
            case (chan_r[2:0]) // one-hot exponent of ratio
                3'h0:    oversampling_log2 <= 9'h004;
                3'h1:    oversampling_log2 <= 9'h008;
                3'h2:    oversampling_log2 <= 9'h010;
                3'h3:    oversampling_log2 <= 9'h020;
                3'h4:    oversampling_log2 <= 9'h001;
                3'h5:    oversampling_log2 <= 9'h002;
                3'h6:    oversampling_log2 <= 9'h040;
                default: oversampling_log2 <= 9'h080;
            endcase
        end
    end
endmodule

//--- prsrd_properties.sv
// pin-level assertions for the pressure readout block
`timescale 1ns/1ns
module prsrd_properties #(
    parameter CONV_CYCLES = 20,
    parameter STEP_CYCLES = 10
) (
    // clock and reset
    input wire       clk,
    input wire       nrst,
    // i2c pins
    input wire       scl_in,
    input wire       sda_out,
    input wire       sda_oe,
    // converter and setup outputs
    input wire       conv_busy,
    input wire       conv_temp_phase,
    input wire       regulator_voltage_select,
    input wire       input_swap,
    input wire [2:0] gain_code,
    input wire [2:0] oversampling_code,
    input wire [8:0] oversampling_log2
);
    localparam int LO = CONV_CYCLES - 1;
    localparam int HI = CONV_CYCLES + 2;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    function automatic [8:0] osr_onehot(input [2:0] c);
        osr_onehot = 9'h001 << (!c[2] ? c + 4'h2 : (c[1] ? c : c[0]));
    endfunction
    sequence s_temp_end;
        ##[LO:HI] $fell(conv_temp_phase);
    endsequence
    sequence s_pres_end;
        ##[LO:HI] $fell(conv_busy);
    endsequence
    property p_open_drain;
        sda_oe |-> !sda_out;
    endproperty
    property p_sda_change;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    property p_temp_first;
        $rose(conv_busy) |-> conv_temp_phase;
    endproperty
    property p_temp_len;
        $rose(conv_temp_phase) |-> s_temp_end;
    endproperty
    property p_pres_len;
        $fell(conv_temp_phase) |-> conv_busy ##0 s_pres_end;
    endproperty
    property p_phase_in_busy;
        conv_temp_phase |-> conv_busy;
    endproperty
    property p_osr_map;
        $past(nrst) ##0 $stable(oversampling_code)[*3]
            |-> oversampling_log2 == osr_onehot(oversampling_code);
    endproperty
    // regulator select, input swap and gain outputs move only just after a bus write
    property p_cfg_quiet;
        $stable(scl_in)[*8] |-> $stable({regulator_voltage_select, input_swap, gain_code});
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("sda driven high while enabled");
    a_sda_change: assert property (p_sda_change)
        else $error("sda changed while scl high");
    a_temp_first: assert property (p_temp_first)
        else $error("conversion did not start with temperature");
    a_temp_len: assert property (p_temp_len)
        else $error("temperature phase length wrong");
    a_pres_len: assert property (p_pres_len)
        else $error("pressure phase missing or wrong length");
    a_phase_in_busy: assert property (p_phase_in_busy)
        else $error("temperature phase outside busy");
    a_osr_map: assert property (p_osr_map)
        else $error("oversampling ratio does not match code");
    a_cfg_quiet: assert property (p_cfg_quiet)
        else $error("setup output changed without bus write");
endmodule
bind prsrd_top prsrd_properties #(
    .CONV_CYCLES(CONV_CYCLES),
    .STEP_CYCLES(STEP_CYCLES)
) prsrd_properties_i (
    .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .conv_busy(conv_busy), .conv_temp_phase(conv_temp_phase),
    .regulator_voltage_select(regulator_voltage_select), .input_swap(input_swap),
    .gain_code(gain_code), .oversampling_code(oversampling_code),
    .oversampling_log2(oversampling_log2)
);

//--- prsrd_i2c_master.sv
// i2c bus master model for the readout block, 80 ns bit time
`timescale 1ns/1ns
`include "prsrd_regs.vh"
module prsrd_i2c_master (
    // serial pins
    output reg  scl,
    output reg  sda_low,
    input  wire sda_line
);
    // scl stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task send_bit(input b);
        #20 sda_low = !b;
        #20 scl = 1'b1;
        #40 scl = 1'b0;
    endtask
    task get_bit(output b);
        #20 sda_low = 1'b0;
        #20 scl = 1'b1;
        #20 b = sda_line;
        #20 scl = 1'b0;
    endtask
    // also serves as repeated start
    task start;
        #20 sda_low = 1'b0;
        #20 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
    endtask
    task stop;
        #20 sda_low = 1'b1;
        #20 scl = 1'b1;
        #40 sda_low = 1'b0;
        #40;
    endtask
    task put_byte(input [7:0] d, output ack);
        reg     b;
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            send_bit(d[i]);
        end
        get_bit(b);
        ack = !b;
    endtask
    task get_byte(input last, output [7:0] d);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            get_bit(d[i]);
        end
        send_bit(last);
    endtask
    task write_reg(input [6:0] dev, input [7:0] ptr, input [7:0] d, output ok);
        reg a0, a1, a2;
        start;
        put_byte({dev, 1'b0}, a0);
        put_byte(ptr, a1);
        put_byte(d, a2);
        stop;
        ok = a0 & a1 & a2;
    endtask
    task read_regs(input [7:0] ptr, input integer n, output [39:0] d, output ok);
        reg       a0, a1, a2;
        reg [7:0] v;
        integer   k;
        d = 40'h0;
        start;
        put_byte({`PRSRD_DEV_ADDR, 1'b0}, a0);
        put_byte(ptr, a1);
        start;
        put_byte({`PRSRD_DEV_ADDR, 1'b1}, a2);
        for (k = 0; k < n; k = k + 1) begin
            get_byte(k == n - 1, v);
            d = {d[31:0], v};
        end
        stop;
        ok = a0 & a1 & a2;
    endtask
endmodule

//--- tb_i2c_pressure_temp_readout.sv
// self-checking bench for the pressure readout block
`timescale 1ns/1ns
`include "prsrd_regs.vh"
module tb_i2c_pressure_temp_readout;
    localparam       CONV = 20;
    localparam       STEP = 10;
    localparam [23:0] OSR_POS = {3'h7, 3'h6, 3'h1, 3'h0, 3'h5, 3'h4, 3'h3, 3'h2};
    reg         clk;
    reg         nrst;
    reg  [23:0] pres_raw;
    reg  [23:0] pres_cal;
    reg  [15:0] temp;
    wire        scl;
    wire        m_low;
    wire        sda_out;
    wire        sda_oe;
    wire        busy;
    wire        tphase;
    wire        reg_sel;
    wire        swap;
    wire [2:0]  gain;
    wire [2:0]  osr;
    wire [8:0]  osr_log2;
    integer     n_errors;
    integer     total_checks;
    reg  [39:0] rd;
    reg         ok;
    // pull-up: both parties only pull low
    wire        sda = !m_low && (sda_oe ? sda_out : 1'b1);
    prsrd_top #(.CONV_CYCLES(CONV), .STEP_CYCLES(STEP)) prsrd_top_i (
        .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .adc_pres_raw(pres_raw), .adc_pres_cal(pres_cal),
        .adc_temp(temp), .conv_busy(busy), .conv_temp_phase(tphase),
        .regulator_voltage_select(reg_sel), .input_swap(swap), .gain_code(gain),
        .oversampling_code(osr), .oversampling_log2(osr_log2));
    prsrd_i2c_master m_i (.scl(scl), .sda_low(m_low), .sda_line(sda));
    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end
    task chk(input [39:0] got, input [39:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize;
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        m_i.write_reg(`PRSRD_DEV_ADDR, a, d, ok);
        chk({39'h0, ok}, 40'h1);
    endtask
    task rdn(input [7:0] a, input integer n);
        m_i.read_regs(a, n, rd, ok);
        chk({39'h0, ok}, 40'h1);
    endtask
    task wait_busy(input v, output integer n);
        n = 0;
        while (busy !== v) begin
            @(negedge clk);
            n = n + 1;
            if (n > 2000) begin
                chk({39'h0, busy}, {39'h0, v});
                summarize;
            end
        end
    endtask
    task s_reset;
        rdn(`PRSRD_OFS_CMD, 1);
        chk(rd, {32'h0, `PRSRD_RST_CMD});
        rdn(`PRSRD_OFS_SYS, 2);
        chk(rd, {24'h0, `PRSRD_RST_SYS, `PRSRD_RST_CHAN});
        rdn(`PRSRD_OFS_PRES_HI, 5);
        chk(rd, 40'h0);
    endtask
    task s_config;
        integer c;
        wr(`PRSRD_OFS_SYS, 8'h08);
        chk({39'h0, reg_sel}, 40'h1);
        for (c = 0; c < 8; c = c + 1) begin
            wr(`PRSRD_OFS_CHAN, {2'b01, c[2:0], ~c[2:0]});
            chk({swap, gain, osr}, {1'b1, c[2:0], ~c[2:0]});
            chk(osr_log2, 9'h001 << OSR_POS[3 * (7 - c) +: 3]);
        end
        wr(`PRSRD_OFS_CHAN, 8'h00);
        chk({39'h0, swap}, 40'h0);
        wr(`PRSRD_OFS_SYS, 8'h00);
        chk({39'h0, reg_sel}, 40'h0);
    endtask
    task s_poll;
        integer i;
        integer pa;
        wr(`PRSRD_OFS_CMD, 8'h0A);
        rd = 40'h8;
        for (i = 0; i < 20 && rd[3] !== 1'b0; i = i + 1) begin
            rdn(`PRSRD_OFS_CMD, 1);
        end
        chk(rd, 40'h0A & ~40'h8);
        if (rd[3] !== 1'b0) begin
            summarize;
        end
        rdn(`PRSRD_OFS_PRES_HI, 5);
        chk(rd, {pres_cal, temp});
        // host side scaling for a plus or minus 100 kPa range
        pa = rd[39:16];
        if (pa >= 32'h800000) begin
            pa = pa - 32'h1000000;
        end
        chk(pa / 64, -16311);
    endtask
    task conv(input [7:0] sys, input [39:0] exp);
        wr(`PRSRD_OFS_SYS, sys);
        wr(`PRSRD_OFS_CMD, 8'h0A);
        repeat (2 * CONV + 8) @(negedge clk);
        rdn(`PRSRD_OFS_PRES_HI, 5);
        chk(rd, exp);
    endtask
    // interval codes 0 and 15 are the boundaries
    task s_sleep;
        integer c;
        integer n;
        for (c = 0; c < 16; c = c + 15) begin
            wr(`PRSRD_OFS_CMD, {c[3:0], 4'hB});
            wait_busy(1'b1, n);
            wait_busy(1'b0, n);
            wait_busy(1'b1, n);
            wait_busy(1'b0, n);
            wait_busy(1'b1, n);
            chk({39'h0, n >= c * STEP && n <= c * STEP + 3}, 40'h1);
            rdn(`PRSRD_OFS_CMD, 1);
            chk(rd, {32'h0, c[3:0], 4'hB});
        end
        wr(`PRSRD_OFS_CMD, 8'h00);
        wait_busy(1'b0, n);
        repeat (200) @(negedge clk);
        chk({39'h0, busy}, 40'h0);
    endtask
    task s_refuse;
        m_i.write_reg(7'h6C, `PRSRD_OFS_CMD, 8'h0A, ok);
        chk({38'h0, ok, busy}, 40'h0);
        wr(`PRSRD_OFS_TEMP_LO, 8'h55);
        rdn(`PRSRD_OFS_TEMP_LO, 1);
        chk(rd, {32'h0, temp[7:0]});
        rdn(8'h10, 1);
        chk(rd, 40'h0);
    endtask
    initial begin
        n_errors = 0;
        total_checks = 0;
        nrst = 1'b0;
        pres_raw = 24'h7ABCDE;
        pres_cal = 24'hF01234;
        temp = 16'h8123;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        s_reset;
        s_config;
        s_poll;
        conv(8'h04, {pres_cal, temp});
        conv(8'h06, {pres_raw ^ 24'h800000, temp ^ 16'h8000});
        conv(8'h02, {pres_raw, temp});
        s_sleep;
        s_refuse;
        summarize;
    end
endmodule
